// ===== core/bas_alu.sv
// Byte ALU slice with AXI4-Lite register access
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps

module bas_alu (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]  file_mem [0:127];  // File registers
  logic [7:0]  acc_reg;           // Accumulator
  logic [4:0]  status_reg;        // Flags
  logic [7:0]  wdog_reg;          // watchdog_counter
  logic [7:0]  pre_reg;           // Watchdog prescaler
  logic [31:0] cmd_reg;           // Last command word
  logic        go_reg;            // Operation executes this cycle
  logic [11:0] waddr_reg;         // Captured write address
  logic [31:0] wdata_reg;         // Captured write data
  logic [3:0]  wstrb_reg;         // Captured byte enables
  logic        wdo_reg;           // Captured write is applied this cycle

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  bas_pkg::bas_op_t op;           // Current opcode
  logic [6:0]  faddr;             // File address
  logic        dest;              // Destination select
  logic [7:0]  lit;               // Literal operand
  logic [7:0]  fval;              // Addressed file value

  assign op    = bas_pkg::bas_op_t'(cmd_reg[bas_pkg::CMD_OP_LSB +: 3]);
  assign faddr = cmd_reg[bas_pkg::CMD_ADDR_LSB +: 7];
  assign dest  = cmd_reg[bas_pkg::CMD_DEST_BIT];
  assign lit   = cmd_reg[bas_pkg::CMD_LIT_LSB +: 8];
  assign fval  = file_mem[faddr];

  // ----------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------
  logic [7:0] res;        // Operation result
  logic [7:0] minuend;    // Subtraction left operand
  logic       borrow_in;  // Incoming borrow
  logic [8:0] diff;       // Full difference with borrow out
  logic [4:0] ndiff;      // Low nibble difference
  logic       new_c;      // Next carry
  logic       new_dc;     // Next half carry
  logic       upd_c;      // Operation writes carry
  logic       upd_arith;  // Operation writes half carry and zero
  logic       wr_res;     // Operation produces a result

  // Subtract helpers: shared by all three subtract flavours
  assign minuend = (op == bas_pkg::BAS_OP_LITERAL_MINUS_ACC) ? lit : fval;
  // Borrow is the inverted carry, only for the borrow form
  assign borrow_in = (op == bas_pkg::BAS_OP_SUB_WITH_BORROW) &
                     ~status_reg[bas_pkg::ST_CARRY];
  assign diff  = {1'b0, minuend} - {1'b0, acc_reg} - {8'h00, borrow_in};
  assign ndiff = {1'b0, minuend[3:0]} - {1'b0, acc_reg[3:0]} - {4'h0, borrow_in};

  // Result and flag selection per opcode
  always_comb begin
    res       = diff[7:0];
    new_c     = ~diff[8];
    new_dc    = ~ndiff[4];
    upd_c     = 1'b0;
    upd_arith = 1'b0;
    wr_res    = 1'b0;
    case (op)
      bas_pkg::BAS_OP_ROTATE_RIGHT_CARRY: begin
        // Old carry enters bit 7, bit 0 leaves as carry
        res    = {status_reg[bas_pkg::ST_CARRY], fval[7:1]};
        new_c  = fval[0];
        upd_c  = 1'b1;
        wr_res = 1'b1;
      end
      bas_pkg::BAS_OP_REG_MINUS_ACC,
      bas_pkg::BAS_OP_LITERAL_MINUS_ACC,
      bas_pkg::BAS_OP_SUB_WITH_BORROW: begin
        upd_c     = 1'b1;
        upd_arith = 1'b1;
        wr_res    = 1'b1;
      end
      bas_pkg::BAS_OP_NIBBLE_EXCHANGE: begin
        // Flags stay untouched by the exchange
        res    = {fval[3:0], fval[7:4]};
        wr_res = 1'b1;
      end
      default: wr_res = 1'b0; // Halt and unused codes produce no result
    endcase
  end

  // ----------------------------------------------------------------
  // Bus write channel
  // ----------------------------------------------------------------
  logic aw_take;  // Address and data accepted this edge
  logic w_map;    // Captured write hits a register

  assign aw_take = s_axi_awready & s_axi_awvalid & s_axi_wready & s_axi_wvalid;
  assign w_map   = (waddr_reg[11:9] == bas_pkg::OFS_FILE[11:9]) ||
                   (waddr_reg == bas_pkg::OFS_CMD) || (waddr_reg == bas_pkg::OFS_ACC) ||
                   (waddr_reg == bas_pkg::OFS_STATUS) || (waddr_reg == bas_pkg::OFS_WDOG);

  // Ready pulses once both channels wait and nothing is in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else if (ce) begin
      if (s_axi_awready) begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
      end else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !wdo_reg && !go_reg) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Capture of the accepted write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      wdo_reg   <= 1'b0;
    end else if (ce) begin
      wdo_reg <= aw_take;
      if (aw_take) begin
        waddr_reg <= {s_axi_awaddr[11:2], 2'b00};
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // Write response raised on the same edge that applies the captured write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= bas_pkg::RESP_OKAY;
    end else if (ce) begin
      if (wdo_reg) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_map ? bas_pkg::RESP_OKAY : bas_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command register and start pulse
  // ----------------------------------------------------------------
  // Start needs the low byte enabled, since it holds the opcode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_reg <= 32'h0000_0000;
      go_reg  <= 1'b0;
    end else if (ce) begin
      go_reg <= 1'b0;
      if (wdo_reg && waddr_reg == bas_pkg::OFS_CMD) begin
        for (int i = 0; i < 4; i++) begin
          if (wstrb_reg[i]) begin
            cmd_reg[i*8 +: 8] <= wdata_reg[i*8 +: 8];
          end
        end
        go_reg <= wstrb_reg[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Accumulator
  // ----------------------------------------------------------------
  // Execution and bus writes never share a cycle: ready is held off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg <= bas_pkg::ACC_RST;
    end else if (ce) begin
      if (go_reg && wr_res &&
          (!dest || op == bas_pkg::BAS_OP_LITERAL_MINUS_ACC)) begin
        acc_reg <= res;
      end else if (wdo_reg && waddr_reg == bas_pkg::OFS_ACC && wstrb_reg[0]) begin
        acc_reg <= wdata_reg[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // File registers, one generate entry per address
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 128; g++) begin : g_file
    // Entry loads from execution or from a bus write to its word
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        file_mem[g] <= 8'h00;
      end else if (ce) begin
        if (go_reg && wr_res && dest && faddr == 7'(g) &&
            op != bas_pkg::BAS_OP_LITERAL_MINUS_ACC) begin
          file_mem[g] <= res;
        end else if (wdo_reg && waddr_reg[11:9] == bas_pkg::OFS_FILE[11:9] &&
                     waddr_reg[8:2] == 7'(g) && wstrb_reg[0]) begin
          file_mem[g] <= wdata_reg[7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  // Software may write the flags; an executing operation cannot
  // collide with that write, so no set-versus-clear race exists
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= bas_pkg::STATUS_RST;
    end else if (ce) begin
      if (go_reg) begin
        if (upd_c) begin
          status_reg[bas_pkg::ST_CARRY] <= new_c;
        end
        if (upd_arith) begin
          status_reg[bas_pkg::ST_HALF] <= new_dc;
          status_reg[bas_pkg::ST_ZERO] <= (res == 8'h00);
        end
        if (op == bas_pkg::BAS_OP_HALT) begin
          // Only these two bits move on halt
          status_reg[bas_pkg::ST_PDOWN]  <= 1'b0;
          status_reg[bas_pkg::ST_EXPIRY] <= 1'b1;
        end
      end else if (wdo_reg && waddr_reg == bas_pkg::OFS_STATUS && wstrb_reg[0]) begin
        status_reg <= wdata_reg[4:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Watchdog counter and prescaler
  // ----------------------------------------------------------------
  // Free-running: counter steps when prescaler wraps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdog_reg <= bas_pkg::WDOG_RST;
      pre_reg  <= bas_pkg::PRE_RST;
    end else if (ce) begin
      if (go_reg && op == bas_pkg::BAS_OP_HALT) begin
        wdog_reg <= 8'h00;
        pre_reg  <= 8'h00;
      end else begin
        pre_reg <= pre_reg + 8'h01;
        if (pre_reg == 8'hff) begin
          wdog_reg <= wdog_reg + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_word;  // Read mux
  logic        rd_map;   // Read address hits a register
  logic [11:0] ra;       // Word-aligned read address
  assign ra = {s_axi_araddr[11:2], 2'b00};

  // Read decode from the live address, sampled at acceptance
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_map  = 1'b1;
    if (ra[11:9] == bas_pkg::OFS_FILE[11:9]) begin
      rd_word[7:0] = file_mem[ra[8:2]];
    end else begin
      case (ra)
        bas_pkg::OFS_CMD:    rd_word = cmd_reg;
        bas_pkg::OFS_ACC:    rd_word[7:0] = acc_reg;
        bas_pkg::OFS_STATUS: begin
          rd_word[4:0]            = status_reg;
          rd_word[bas_pkg::ST_BUSY] = go_reg;
        end
        bas_pkg::OFS_WDOG: begin
          rd_word[7:0]                           = wdog_reg;
          rd_word[bas_pkg::WDOG_PRE_LSB +: 8] = pre_reg;
        end
        default: rd_map = 1'b0;
      endcase
    end
  end

  // Ready pulses for one cycle, data follows on the next edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= bas_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_map ? bas_pkg::RESP_OKAY : bas_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : bas_alu

// ===== core/bas_pkg.sv
// Constants, opcodes and register map of the byte ALU slice
package bas_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CMD    = 12'h000; // Command, write with byte 0 enabled starts an operation
  localparam logic [11:0] OFS_ACC    = 12'h004; // Accumulator
  localparam logic [11:0] OFS_STATUS = 12'h008; // Status flags
  localparam logic [11:0] OFS_WDOG   = 12'h00c; // Watchdog counter and prescaler, read only
  localparam logic [11:0] OFS_FILE   = 12'h200; // Base of 128 file registers, one per word

  // ----------------------------------------------------------------
  // Command field positions
  // ----------------------------------------------------------------
  localparam int CMD_OP_LSB   = 0;  // Opcode, 3 bits
  localparam int CMD_DEST_BIT = 3;  // Destination: 0 accumulator, 1 file register; literal minus accumulator always writes the accumulator
  localparam int CMD_ADDR_LSB = 4;  // File address, 7 bits
  localparam int CMD_LIT_LSB  = 16; // Literal, 8 bits

  // ----------------------------------------------------------------
  // Status bit positions
  // ----------------------------------------------------------------
  localparam int ST_CARRY   = 0;
  localparam int ST_HALF    = 1;
  localparam int ST_ZERO    = 2;
  localparam int ST_PDOWN   = 3;
  localparam int ST_EXPIRY  = 4;
  localparam int ST_BUSY    = 8;
  localparam int WDOG_PRE_LSB = 16; // Prescaler field within the watchdog word

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_RST    = 8'h00;
  localparam logic [4:0] STATUS_RST = 5'h18; // Power-down and expiry set after reset
  localparam logic [7:0] WDOG_RST   = 8'h00;
  localparam logic [7:0] PRE_RST    = 8'h00;

  // ----------------------------------------------------------------
  // Bus responses
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operation codes carried in the command word
  typedef enum logic [2:0] {
    BAS_OP_ROTATE_RIGHT_CARRY = 3'h0, // rotate_right_carry_op
    BAS_OP_REG_MINUS_ACC      = 3'h1, // reg_minus_acc_op
    BAS_OP_LITERAL_MINUS_ACC  = 3'h2, // literal_minus_acc_op
    BAS_OP_SUB_WITH_BORROW    = 3'h3, // sub_with_borrow_op
    BAS_OP_NIBBLE_EXCHANGE    = 3'h4, // nibble_exchange_op
    BAS_OP_HALT               = 3'h5  // Low-power halt side effects
  } bas_op_t;

endpackage : bas_pkg

// ===== verification/bas_alu_asserts.sv
// Bus protocol checker for the byte ALU slice
`timescale 1ns/1ps

module bas_alu_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  // ----------------------------------------------------------------
  // Clocking and handshake steps
  // ----------------------------------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce); // Frozen cycles hold state, so skip them
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_wr_answer; s_wr_take |-> ##[1:3] s_axi_bvalid; endproperty
  property p_rd_answer; s_rd_take |-> ##[1:2] s_axi_rvalid; endproperty
  property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
  property p_ar_pulse; s_axi_arready |=> !s_axi_arready; endproperty
  property p_w_pair; s_axi_awready |-> s_axi_wready; endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  property p_aw_busy; s_axi_bvalid |-> !s_axi_awready; endproperty
  property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  // Own disable: the frozen cycles are exactly what this one watches
  property p_frozen;
    disable iff (!aresetn)
    !ce |=> $stable(s_axi_awready) && $stable(s_axi_arready) &&
            $stable(s_axi_bvalid) && $stable(s_axi_rvalid) && $stable(s_axi_rdata);
  endproperty

  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  a_aw_pulse: assert property (p_aw_pulse) else $error("awready too long");
  a_ar_pulse: assert property (p_ar_pulse) else $error("arready too long");
  a_w_pair: assert property (p_w_pair) else $error("wready apart from awready");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  a_b_drop: assert property (p_b_drop) else $error("bvalid stuck");
  a_aw_busy: assert property (p_aw_busy) else $error("write taken while busy");
  a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
  a_frozen: assert property (p_frozen) else $error("outputs moved while frozen");
endmodule : bas_alu_asserts

bind bas_alu bas_alu_asserts bas_alu_asserts_inst (.aclk, .aresetn, .ce, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ===== verification/bas_alu_tb_top.sv
// Self-checking bench for the byte ALU slice
`timescale 1ns/1ps

module bas_alu_tb_top;
  typedef struct packed {logic [31:0] dat; logic [31:0] msk; logic [1:0] rsp;} bas_note_t;
  logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  bas_note_t   rq[$], n;             // Expected read answers, oldest first
  logic [1:0]  bq[$];                // Expected write responses
  int          mismatches, cmp_count;
  logic [7:0]  m_acc, m_file [128];  // Reference accumulator and file
  logic        m_c, m_dc, m_z, m_pd, m_to;
  logic [6:0]  a;

  bas_alu bas_alu_inst (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Watcher: each answer handshake consumes the oldest note
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
      n = rq.pop_front();
      check("rdata", s_axi_rdata & n.msk, n.dat);
      check("rresp", {30'h0, s_axi_rresp}, {30'h0, n.rsp});
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
      check("bresp", {30'h0, s_axi_bresp}, {30'h0, bq.pop_front()});
    end
  end

  task automatic wr(input logic [11:0] ad, input logic [31:0] dt, input logic [1:0] r);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Each channel is released at the edge that takes it, in either order
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] ad, input logic [31:0] dt, input logic [31:0] m,
                    input logic [1:0] r);
    rq.push_back('{dt, m, r});
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask : rd

  // Runs one command on the model, then on the design, then reads back
  task automatic op(input logic [2:0] o, input logic dst, input logic [6:0] f,
                    input logic [7:0] k);
    logic [7:0] src, res;
    logic [8:0] t;
    logic [4:0] h;
    logic       b;
    src = (o == 3'h2) ? k : m_file[f];
    b = (o == 3'h3) ? !m_c : 1'b0;
    t = {1'b0, src} - {1'b0, m_acc} - {8'h00, b};
    h = {1'b0, src[3:0]} - {1'b0, m_acc[3:0]} - {4'h0, b};
    res = t[7:0];
    case (o)
      3'h0: begin res = {m_c, src[7:1]}; m_c = src[0]; end
      3'h4: res = {src[3:0], src[7:4]};
      3'h5: begin m_pd = 1'b0; m_to = 1'b1; end
      default: begin m_c = !t[8]; m_dc = !h[4]; m_z = (res == 8'h00); end
    endcase
    if (o != 3'h5 && dst && o != 3'h2) m_file[f] = res;
    else if (o != 3'h5) m_acc = res;
    wr(bas_pkg::OFS_CMD, {8'h00, k, 5'h00, f, dst, o}, bas_pkg::RESP_OKAY);
    rd(bas_pkg::OFS_ACC, {24'h0, m_acc}, 32'hffffffff, bas_pkg::RESP_OKAY);
    rd(bas_pkg::OFS_STATUS, {27'h0, m_to, m_pd, m_z, m_dc, m_c}, 32'hffffffff, 2'h0);
    rd(bas_pkg::OFS_FILE + {3'h0, f, 2'h0}, {24'h0, m_file[f]}, 32'hffffffff, 2'h0);
    // Counter and upper prescaler bits are still zero this soon after halt
    if (o == 3'h5) rd(bas_pkg::OFS_WDOG, 32'h0, 32'h00e000ff, 2'h0);
  endtask : op

  task automatic report_and_stop;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop

  // Hang guard, far beyond the expected few thousand cycles
  initial begin
    #(50 * 20000);
    mismatches++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    ce = 1'b1; // Running; the freeze scenario drops it near the end
    {mismatches, cmp_count} = '0;
    {m_acc, m_to, m_pd, m_z, m_dc, m_c} = {bas_pkg::ACC_RST, bas_pkg::STATUS_RST};
    foreach (m_file[i]) m_file[i] = 8'h00;
    void'($urandom(27));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(bas_pkg::OFS_STATUS, 32'h18, 32'hffffffff, 2'h0);
    rd(bas_pkg::OFS_FILE + 12'h1fc, 32'h0, 32'hffffffff, 2'h0);
    wr(12'h010, 32'h5a, bas_pkg::RESP_SLVERR); // Unmapped place refused
    rd(12'h010, 32'h0, 32'hffffffff, bas_pkg::RESP_SLVERR);
    // Command without lane 0 stores upper bytes but must not start the halt
    s_axi_wstrb <= 4'he;
    wr(bas_pkg::OFS_CMD, 32'h0012_3405, bas_pkg::RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(bas_pkg::OFS_CMD, 32'h0012_3400, 32'hffffffff, 2'h0);
    rd(bas_pkg::OFS_STATUS, 32'h18, 32'hffffffff, 2'h0);
    for (int i = 0; i < 60; i++) begin
      a = (i < 12) ? (i[0] ? 7'h7f : 7'h00) : 7'($urandom);
      d = $urandom;
      m_file[a] = d[7:0];
      wr(bas_pkg::OFS_FILE + {3'h0, a, 2'h0}, d, 2'h0);
      d = $urandom;
      m_acc = d[7:0];
      wr(bas_pkg::OFS_ACC, d, 2'h0);
      op((i < 12) ? 3'(i % 6) : 3'($urandom_range(5, 0)), 1'($urandom), a, 8'($urandom));
    end
    // Freeze the block while a read waits; it must finish once ce returns
    fork
      rd(bas_pkg::OFS_ACC, {24'h0, m_acc}, 32'hffffffff, 2'h0);
      begin
        ce <= 1'b0;
        repeat (6) @(posedge aclk);
        ce <= 1'b1;
      end
    join
    report_and_stop();
  end
endmodule : bas_alu_tb_top
